// [core/iomp_pkg.sv]
package iomp_pkg;
    // processor bit k (big-endian) sits at vector bit 31-k
    localparam int IOMP_BASE_MSB = 31;
    localparam int IOMP_BASE_LSB = 24;
    localparam int IOMP_FA_MSB   = 23;
    localparam int IOMP_FA_LSB   = 3;
    localparam int IOMP_BASE_W   = 8;
    localparam int IOMP_FA_W     = 21;
    localparam int IOMP_DATA_W   = 32;

    localparam logic [1:0] IOMP_SEL_BASE = 2'h0;
    localparam logic [1:0] IOMP_SEL_INIT = 2'h1;
    localparam logic [1:0] IOMP_SEL_FILL = 2'h2;

    localparam logic [IOMP_BASE_W-1:0] IOMP_BASE_RST = 8'h00;
    localparam logic [IOMP_FA_W-1:0]   IOMP_INIT_RST = 21'h000000;
    localparam logic [IOMP_DATA_W-1:0] IOMP_FILL_RST = 32'h00000000;

    typedef enum logic [1:0] {
        IOMP_IDLE   = 2'b00,
        IOMP_SETUP  = 2'b01,
        IOMP_STROBE = 2'b11
    } iomp_state_t;

    function automatic logic iomp_region_hit(input logic [31:0] addr, input logic [IOMP_BASE_W-1:0] base);
        iomp_region_hit = (addr[IOMP_BASE_MSB:IOMP_BASE_LSB] == base);
    endfunction

    function automatic logic [IOMP_FA_W-1:0] iomp_fetch_index(input logic [31:0] addr);
        iomp_fetch_index = addr[IOMP_FA_MSB:IOMP_FA_LSB];
    endfunction
endpackage

// [core/iomp_cfg_regs.sv]
`timescale 1ns/1ps
module iomp_cfg_regs
    import iomp_pkg::*;
(
    input  wire logic                   mclk,
    input  wire logic                   nrst,
    input  wire logic                   cfg_wr,
    input  wire logic [1:0]             cfg_sel,
    input  wire logic [IOMP_DATA_W-1:0] cfg_wdata,
    output logic      [IOMP_BASE_W-1:0] region_base_r,
    output logic      [IOMP_FA_W-1:0]   addr_init_r,
    output logic      [IOMP_DATA_W-1:0] fill_r
);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            region_base_r <= IOMP_BASE_RST;
        end else if (cfg_wr && cfg_sel == IOMP_SEL_BASE) begin
            region_base_r <= cfg_wdata[IOMP_BASE_W-1:0];
        end
    end

    // no strap path: these two only ever change on reset or a software write
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            addr_init_r <= IOMP_INIT_RST;
            fill_r      <= IOMP_FILL_RST;
        end else if (cfg_wr) begin
            if (cfg_sel == IOMP_SEL_INIT) begin
                addr_init_r <= cfg_wdata[IOMP_FA_W-1:0];
            end
            if (cfg_sel == IOMP_SEL_FILL) begin
                fill_r <= cfg_wdata;
            end
        end
    end

endmodule

// [core/iomp_top.sv]
`timescale 1ns/1ps
module iomp_top
    import iomp_pkg::*;
#(
    parameter bit NEWER_GEN = 1'b1
)(
    input  wire logic                   mclk,
    input  wire logic                   nrst,
    input  wire logic                   cpu_fetch_valid,
    input  wire logic [31:0]            cpu_fetch_addr,
    input  wire logic                   cfg_wr,
    input  wire logic [1:0]             cfg_sel,
    input  wire logic [IOMP_DATA_W-1:0] cfg_wdata,
    input  wire logic                   dbg_req,
    input  wire logic                   dbg_write,
    input  wire logic                   dbg_odd,
    output logic                        fetch_mem_enable,
    output logic      [IOMP_FA_W-1:0]   fetch_read_addr,
    output logic      [IOMP_FA_W-1:0]   debug_access_addr,
    output logic      [IOMP_DATA_W-1:0] debug_write_data,
    output logic                        odd_bank_write_en,
    output logic                        even_bank_write_en,
    output logic                        odd_bank_access_en,
    output logic                        even_bank_access_en,
    output logic                        debug_word_select,
    output logic                        debug_busy
);

    logic [IOMP_BASE_W-1:0] region_base_r;
    logic [IOMP_FA_W-1:0]   addr_init_r;
    logic [IOMP_DATA_W-1:0] fill_r;
    iomp_state_t            state_r;
    iomp_state_t            state_nxt;
    logic                   op_write_r;
    logic                   op_odd_r;
    logic                   fetch_hit;
    logic                   dbg_accept;
    logic                   dbg_allowed;

    iomp_cfg_regs u_cfg (
        .mclk          (mclk),
        .nrst          (nrst),
        .cfg_wr        (cfg_wr),
        .cfg_sel       (cfg_sel),
        .cfg_wdata     (cfg_wdata),
        .region_base_r (region_base_r),
        .addr_init_r   (addr_init_r),
        .fill_r        (fill_r)
    );

    assign fetch_hit = cpu_fetch_valid && iomp_region_hit(cpu_fetch_addr, region_base_r);
    // older parts have no debug read path through this port
    assign dbg_allowed = dbg_write || NEWER_GEN;
    assign dbg_accept  = dbg_req && dbg_allowed && state_r == IOMP_IDLE;

    // enable stays low outside matching fetches to save memory power
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            fetch_mem_enable <= 1'b0;
        end else begin
            fetch_mem_enable <= fetch_hit;
        end
    end

    // address holds between fetches, avoiding needless toggling
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            fetch_read_addr <= '0;
        end else if (fetch_hit) begin
            fetch_read_addr <= iomp_fetch_index(cpu_fetch_addr);
        end
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            IOMP_IDLE: begin
                if (dbg_accept) begin
                    state_nxt = IOMP_SETUP;
                end
            end
            IOMP_SETUP: begin
                state_nxt = IOMP_STROBE;
            end
            IOMP_STROBE: begin
                state_nxt = IOMP_IDLE;
            end
            default: begin
                state_nxt = IOMP_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_r <= IOMP_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            op_write_r <= 1'b0;
            op_odd_r   <= 1'b0;
        end else if (dbg_accept) begin
            op_write_r <= dbg_write;
            op_odd_r   <= dbg_odd;
        end
    end

    // address and data settle one cycle ahead of the strobe
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            debug_access_addr <= IOMP_INIT_RST;
            debug_write_data  <= IOMP_FILL_RST;
        end else if (dbg_accept) begin
            debug_access_addr <= addr_init_r;
            debug_write_data  <= fill_r;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            debug_word_select <= 1'b0;
        end else if (dbg_accept) begin
            debug_word_select <= dbg_odd;
        end
    end

    // strobes last exactly one cycle per access
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            odd_bank_write_en  <= 1'b0;
            even_bank_write_en <= 1'b0;
        end else begin
            odd_bank_write_en  <= state_r == IOMP_SETUP && op_write_r && op_odd_r;
            even_bank_write_en <= state_r == IOMP_SETUP && op_write_r && !op_odd_r;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            odd_bank_access_en  <= 1'b0;
            even_bank_access_en <= 1'b0;
        end else begin
            odd_bank_access_en  <= NEWER_GEN && state_r == IOMP_SETUP && op_odd_r;
            even_bank_access_en <= NEWER_GEN && state_r == IOMP_SETUP && !op_odd_r;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            debug_busy <= 1'b0;
        end else begin
            debug_busy <= state_nxt != IOMP_IDLE;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    fetch_enable_a: assert property (fetch_hit |=> fetch_mem_enable)
        else $error("fetch enable missing after hit");
    fetch_idle_a: assert property (!fetch_hit |=> !fetch_mem_enable)
        else $error("fetch enable without valid hit");
    fetch_addr_a: assert property (fetch_hit |=> fetch_read_addr == $past(cpu_fetch_addr[23:3]))
        else $error("fetch address wrong bits");
    base_miss_a: assert property (cpu_fetch_valid && cpu_fetch_addr[31:24] != region_base_r
                                  |=> !fetch_mem_enable)
        else $error("fetch enabled on base mismatch");
    dbg_addr_init_a: assert property (dbg_accept |=> debug_access_addr == $past(addr_init_r))
        else $error("debug address not from init register");
    dbg_fill_data_a: assert property (dbg_accept |=> debug_write_data == $past(fill_r))
        else $error("debug data not from fill register");
    odd_write_a: assert property (dbg_accept && dbg_write && dbg_odd |-> ##2 odd_bank_write_en ##1 !odd_bank_write_en)
        else $error("odd write strobe wrong");
    even_write_a: assert property (dbg_accept && dbg_write && !dbg_odd |-> ##2 even_bank_write_en && !odd_bank_write_en)
        else $error("even write strobe wrong");
    word_select_a: assert property (dbg_accept |=> debug_word_select == $past(dbg_odd))
        else $error("word select mismatch");
    strobe_stable_a: assert property ((odd_bank_write_en || even_bank_write_en) |-> $stable(debug_access_addr)
                                      && $stable(debug_write_data))
        else $error("address or data moved under strobe");
    read_access_a: assert property (dbg_accept && !dbg_write |-> ##2 (odd_bank_access_en || even_bank_access_en)
                                    && !odd_bank_write_en && !even_bank_write_en)
        else $error("debug read did not strobe access enable");

    fetch_cov: cover property (fetch_hit ##1 fetch_mem_enable);
    odd_write_cov: cover property (odd_bank_write_en);
    read_cov: cover property (dbg_accept && !dbg_write);

endmodule

// [verif/iomp_block_mem.sv]
`timescale 1ns/1ps
module iomp_block_mem
    import iomp_pkg::*;
#(
    parameter bit NEWER_GEN = 1'b1,
    parameter bit TIE_EN    = 1'b0
)(
    input  wire logic                   mclk,
    input  wire logic                   fetch_mem_enable,
    input  wire logic [IOMP_FA_W-1:0]   fetch_read_addr,
    input  wire logic [IOMP_FA_W-1:0]   debug_access_addr,
    input  wire logic [IOMP_DATA_W-1:0] debug_write_data,
    input  wire logic                   odd_bank_write_en,
    input  wire logic                   even_bank_write_en,
    input  wire logic                   odd_bank_access_en,
    input  wire logic                   even_bank_access_en,
    input  wire logic                   debug_word_select,
    output logic      [63:0]            fetch_read_data,
    output logic      [IOMP_DATA_W-1:0] debug_read_data
);
    logic [63:0] mem [16];
    logic        odd_en;
    logic        even_en;
    logic [3:0]  wa;
    // older parts gate the second port with the write enable itself
    assign odd_en  = NEWER_GEN ? odd_bank_access_en : odd_bank_write_en;
    assign even_en = NEWER_GEN ? even_bank_access_en : even_bank_write_en;
    // only 16 words modelled, upper address bits alias
    assign wa = debug_access_addr[3:0];
    always_ff @(posedge mclk) begin
        if (TIE_EN || fetch_mem_enable) begin
            fetch_read_data <= mem[fetch_read_addr[3:0]];
        end
        if (odd_en && odd_bank_write_en) begin
            mem[wa][31:0] <= debug_write_data;
        end
        if (even_en && even_bank_write_en) begin
            mem[wa][63:32] <= debug_write_data;
        end
        if (odd_en || even_en) begin
            debug_read_data <= debug_word_select ? mem[wa][31:0] : mem[wa][63:32];
        end
    end
endmodule

// [verif/iomp_top_tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module iomp_top_tb
    import iomp_pkg::*;
;
    logic        mclk, nrst, fv, cfg_wr, dbg_req, dbg_write, dbg_odd;
    logic [31:0] fa, cfg_wdata, drd;
    logic [1:0]  cfg_sel;
    logic        fen, owe, ewe, oen, een, wsel, busy;
    logic [20:0] fra, daa;
    logic [31:0] dwd;
    logic [63:0] frd;
    logic        fen_o, owe_o, ewe_o, oen_o, een_o, wsel_o, busy_o;
    logic [20:0] fra_o, daa_o;
    logic [31:0] dwd_o;
    logic [63:0] frd_o;
    int          mismatches, cmp_count, cycles;
    logic [20:0] last_ra;
    typedef struct { logic [7:0] base; logic [31:0] addr; logic v; logic en; } iomp_row_t;
    iomp_row_t rows [6] = '{'{8'h12, 32'h12FFFFF8, 1, 1}, '{8'h12, 32'h13FFFFF8, 1, 0},
        '{8'h12, 32'h12000000, 0, 0}, '{8'hFF, 32'hFF000008, 1, 1},
        '{8'h00, 32'h00FFFFF8, 1, 1}, '{8'h80, 32'h7F000000, 1, 0}};

    iomp_top iomp_top_inst (.mclk(mclk), .nrst(nrst), .cpu_fetch_valid(fv), .cpu_fetch_addr(fa),
        .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata), .dbg_req(dbg_req),
        .dbg_write(dbg_write), .dbg_odd(dbg_odd), .fetch_mem_enable(fen), .fetch_read_addr(fra),
        .debug_access_addr(daa), .debug_write_data(dwd), .odd_bank_write_en(owe),
        .even_bank_write_en(ewe), .odd_bank_access_en(oen), .even_bank_access_en(een),
        .debug_word_select(wsel), .debug_busy(busy));
    iomp_block_mem iomp_block_mem_inst (.mclk(mclk), .fetch_mem_enable(fen), .fetch_read_addr(fra),
        .debug_access_addr(daa), .debug_write_data(dwd), .odd_bank_write_en(owe),
        .even_bank_write_en(ewe), .odd_bank_access_en(oen), .even_bank_access_en(een),
        .debug_word_select(wsel), .fetch_read_data(frd), .debug_read_data(drd));
    // older generation beside the newer one, same stimulus; its memory ties enable high
    iomp_top #(.NEWER_GEN(1'b0)) iomp_top_old_inst (.mclk(mclk), .nrst(nrst), .cpu_fetch_valid(fv),
        .cpu_fetch_addr(fa), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata), .dbg_req(dbg_req),
        .dbg_write(dbg_write), .dbg_odd(dbg_odd), .fetch_mem_enable(fen_o), .fetch_read_addr(fra_o),
        .debug_access_addr(daa_o), .debug_write_data(dwd_o), .odd_bank_write_en(owe_o),
        .even_bank_write_en(ewe_o), .odd_bank_access_en(oen_o), .even_bank_access_en(een_o),
        .debug_word_select(wsel_o), .debug_busy(busy_o));
    iomp_block_mem #(.NEWER_GEN(1'b0), .TIE_EN(1'b1)) iomp_block_mem_old_inst (.mclk(mclk),
        .fetch_mem_enable(fen_o), .fetch_read_addr(fra_o), .debug_access_addr(daa_o),
        .debug_write_data(dwd_o), .odd_bank_write_en(owe_o), .even_bank_write_en(ewe_o),
        .odd_bank_access_en(oen_o), .even_bank_access_en(een_o), .debug_word_select(wsel_o),
        .fetch_read_data(frd_o), .debug_read_data());

    initial begin
        mclk = 0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic give_verdict();
        $display("compares=%0d mismatches=%0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic cfg(input logic [1:0] s, input logic [31:0] d);
        @(posedge mclk);
        cfg_wr <= 1; cfg_sel <= s; cfg_wdata <= d;
        @(posedge mclk);
        cfg_wr <= 0;
    endtask
    task automatic dbg(input logic w, input logic o, input logic [20:0] ea, input logic [31:0] ed,
                       input logic poke);
        @(posedge mclk);
        dbg_req <= 1; dbg_write <= w; dbg_odd <= o;
        @(posedge mclk);
        if (poke) dbg_odd <= !o;
        else dbg_req <= 0;
        @(negedge mclk);
        `CHK(daa, ea)
        `CHK(dwd, ed)
        `CHK(busy, 1'b1)
        `CHK(busy_o, w)
        `CHK({daa_o, dwd_o}, {ea, ed})
        @(posedge mclk);
        dbg_req <= 0;
        @(negedge mclk);
        `CHK({owe, ewe}, {w & o, w & !o})
        `CHK({oen, een}, {o, !o})
        `CHK({owe_o, ewe_o, oen_o, een_o}, {w & o, w & !o, 2'h0})
        @(negedge mclk);
        `CHK({owe, ewe, oen, een, busy}, 5'h00)
        `CHK(wsel, o)
        `CHK({owe_o, ewe_o, busy_o}, 3'h0)
        if (w) `CHK(wsel_o, o)
    endtask

    initial begin
        {nrst, fv, cfg_wr, dbg_req, dbg_write, dbg_odd} = '0;
        {fa, cfg_wdata, cfg_sel} = '0;
        mismatches = 0; cmp_count = 0; cycles = 0; last_ra = '0;
        repeat (16) @(posedge mclk);
        `CHK({fen, owe, ewe, oen, een, busy, fra, daa, dwd}, '0)
        `CHK({fen_o, owe_o, ewe_o, busy_o, fra_o, daa_o, dwd_o}, '0)
        nrst <= 1;
        foreach (rows[i]) begin
            cfg(IOMP_SEL_BASE, {24'h0, rows[i].base});
            fv <= rows[i].v; fa <= rows[i].addr;
            @(posedge mclk);
            fv <= 0;
            @(negedge mclk);
            if (rows[i].en) last_ra = rows[i].addr[23:3];
            `CHK(fen, rows[i].en)
            `CHK(fra, last_ra)
        end
        cfg(IOMP_SEL_INIT, 32'h00000005);
        cfg(IOMP_SEL_FILL, 32'hCAFEF00D);
        cfg(2'h3, 32'hFFFFFFFF); // ignored select
        dbg(1, 1, 21'h5, 32'hCAFEF00D, 0);
        cfg(IOMP_SEL_FILL, 32'h12345678);
        dbg(1, 0, 21'h5, 32'h12345678, 1);
        dbg(0, 1, 21'h5, 32'h12345678, 0);
        `CHK(drd, 32'hCAFEF00D)
        cfg(IOMP_SEL_BASE, 32'h00000012);
        fv <= 1; fa <= 32'h12000028;
        @(posedge mclk);
        fv <= 0;
        @(posedge mclk);
        @(negedge mclk);
        `CHK(frd, 64'h12345678CAFEF00D)
        `CHK(fen, 1'b0)
        `CHK(frd_o, 64'h12345678CAFEF00D)
        `CHK(fra_o, 21'h000005)
        // mid-run reset: init and fill fall back to reset values, not to any strap
        nrst <= 0;
        @(posedge mclk);
        @(negedge mclk);
        `CHK({fen, owe, ewe, oen, een, busy, wsel, daa, dwd}, '0)
        @(posedge mclk);
        nrst <= 1;
        dbg(1, 0, IOMP_INIT_RST, IOMP_FILL_RST, 0);
        give_verdict();
    end
endmodule
